// File: prs_pkg.sv
// Shared constants and types for the reference switchover and post-divider block.
// Assumes a single 25 MHz system clock that samples both reference inputs.
package prs_pkg;

    // System clock
    localparam int CLK_PERIOD_NS   = 40;
    localparam int CLK_FREQ_MHZ    = 25;

    // Post-divider counts, high and low time each up to the 512 maximum
    localparam int DIV_CNT_W       = 10;
    localparam int DIV_MAX_COUNT   = 512;
    localparam int DIV_NUM         = 2;
    localparam logic [DIV_CNT_W-1:0] DIV_CNT_ONE   = 10'h001;
    localparam logic [DIV_CNT_W-1:0] DIV_CNT_RESET = 10'h000;

    // Loss detection: a reference is lost after about two of its own periods
    localparam int LOSS_REF_CYCLES = 2;
    localparam int REF_PERIOD_CYC  = 4;
    localparam int LOSS_CNT_W      = 8;

    // Selection encoding and reset values
    localparam logic SEL_PRIMARY   = 1'b0;
    localparam logic SEL_BACKUP    = 1'b1;
    localparam logic CHAIN_RESET   = 1'b0;

    // Switchover sequencer, Gray coded along run -> gate -> swap; swap -> run flips both bits
    typedef enum logic [1:0] {
        PRS_RUN  = 2'b00,
        PRS_GATE = 2'b01,
        PRS_SWAP = 2'b11
    } prs_state_e;

    // High and low time counts of one post-divider
    typedef struct packed {
        logic [DIV_CNT_W-1:0] high_cnt;
        logic [DIV_CNT_W-1:0] low_cnt;
    } prs_div_cfg_s;

    // Status seen by user logic
    typedef struct packed {
        logic primary_ref_loss_flag;
        logic backup_ref_loss_flag;
        logic active_sel;
    } prs_status_s;

endpackage

// File: prs_ref_model.sv
// Far-side model: two reference clock sources that user logic can stop and restart.
// Assumes the bench clock runs far faster than the references; outputs change on clk falling edges.
`timescale 1ns/1ps
module prs_ref_model
    import prs_pkg::*;
#(
    parameter int HALF = REF_PERIOD_CYC / 2   // Clk cycles per reference half period
) (
    input  wire logic clk,                    // System clock
    input  wire logic run_primary,            // Primary source running
    input  wire logic run_backup,             // Backup source running
    output logic      primary_ref_input,      // Primary reference clock
    output logic      backup_ref_input        // Backup reference clock
);
    int p_cnt = 0;
    int b_cnt = 1;

    initial primary_ref_input = 1'b0;
    initial backup_ref_input  = 1'b0;

    // same frequency
    // Both sources share one period so loss flags stay valid; backup is offset by one clk
    always @(negedge clk) begin
        p_cnt = (p_cnt + 1) % HALF;
        b_cnt = (b_cnt + 1) % HALF;
        // A stopped source holds its level, as a dead oscillator would
        if (run_primary && p_cnt == 0) begin
            primary_ref_input <= ~primary_ref_input;
        end
        if (run_backup && b_cnt == 0) begin
            backup_ref_input <= ~backup_ref_input;
        end
    end
endmodule

// File: prs_ref_switch.sv
// Reference switchover with loss detection, glitch-free gating and two post-dividers.
// Assumes both reference inputs are synchronous to clk and slower than clk / 2.
//
// Behaviour
// - Chained dividers divide by product of settings.
// - Chaining fixed at start, never changed later.
// - Duty cycle from separate high/low counts.
// - Duty step is one over divide value.
// - Phase-detector enable low stops loop corrections.
// - Automatic mode moves off an absent reference.
// - Drive two loss flags and active selection.
// - Loss flag after two idle reference cycles.
// - Automatic switching works both ways, repeatedly.
// - Only rising edge of request starts switch.
// - Gate on old fall, swap on new fall.
// - Selection follows request; no flags while toggling.
// - Falling request never switches back.
// - Wait for target reference before completing.
// - High request blocks any further switch action.
// - Manual switch tolerates references beyond 20%.
`timescale 1ns/1ps
module prs_ref_switch
    import prs_pkg::*;
#(
    parameter int REF_PERIOD = REF_PERIOD_CYC,    // Clk cycles per reference period
    parameter int CNT_W      = DIV_CNT_W          // Post-divider count width, only checked; counters use DIV_CNT_W
) (
    input  wire logic         clk,                // System clock, 25 MHz
    input  wire logic         nrst,               // Asynchronous reset, active low
    input  wire logic         primary_ref_input,  // Primary reference clock
    input  wire logic         backup_ref_input,   // Backup reference clock
    input  wire logic         manual_switch_req,  // Manual switch request
    input  wire logic         pfd_enable,         // Phase-detector enable
    input  wire logic         loop_reset,         // Loop reset, clears dividers
    input  wire logic         chain_cfg,          // Chaining strap, taken once
    input  wire prs_div_cfg_s div_cfg [DIV_NUM],  // High/low counts per divider
    output prs_status_s       status,             // Loss flags and selection
    output logic              ref_feed,           // Gated, muxed reference
    output logic              pfd_correct_en,     // Phase corrections allowed
    output logic              chain_active,       // Chaining in force
    output logic              post_divider_first, // First divider output
    output logic              post_divider_second // Second divider output
);

    localparam int LOSS_CYC = LOSS_REF_CYCLES * REF_PERIOD;

    // Refuse settings that the counters cannot hold
    if (CNT_W < DIV_CNT_W || LOSS_CYC >= (1 << LOSS_CNT_W) || REF_PERIOD < 2) begin : g_bad_param
        $error("prs_ref_switch: unsupported parameter values");
    end

    localparam logic [LOSS_CNT_W-1:0] LOSS_LIMIT = LOSS_CNT_W'(LOSS_CYC - 1);

    // Zero counts are served as one so a divider never stalls
    function automatic logic [DIV_CNT_W-1:0] eff_cnt(input logic [DIV_CNT_W-1:0] c);
        eff_cnt = (c == DIV_CNT_RESET) ? DIV_CNT_ONE : c;
    endfunction

    logic             rst_meta_reg;
    logic             rst_n_reg;
    logic [1:0]       ref_prev_reg;
    logic [1:0]       ref_now;
    logic [1:0]       ref_fall;
    logic [1:0]       ref_edge;
    logic [LOSS_CNT_W-1:0] idle_cnt_reg [2];
    logic [1:0]       loss_reg;
    logic             sel_reg;
    logic             gate_reg;
    logic             req_prev_reg;
    logic             req_rise;
    logic             auto_trig;
    prs_state_e       state_reg;
    prs_state_e       state_next;
    logic             feed_reg;
    logic             feed_rise;
    logic             cfg_taken_reg;
    logic             chain_reg;
    logic             pfd_reg;
    logic [DIV_CNT_W-1:0] div_cnt_reg [DIV_NUM];
    logic [DIV_NUM-1:0]   div_out_reg;
    logic [DIV_NUM-1:0]   div_prev_reg;
    logic [DIV_NUM-1:0]   div_tick;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // Edge detection of both references
    assign ref_now  = {backup_ref_input, primary_ref_input};
    assign ref_fall = ref_prev_reg & ~ref_now;
    assign ref_edge = ref_prev_reg ^ ref_now;

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ref_prev_reg <= 2'h0;
        end else begin
            ref_prev_reg <= ref_now;
        end
    end

    // idle counting
    // Count clk cycles since each reference last changed level
    // flag clears on toggle
    // An edge restarts the count and drops the flag again
    for (genvar i = 0; i < 2; i++) begin : g_loss
        always_ff @(posedge clk or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
                idle_cnt_reg[i] <= {LOSS_CNT_W{1'b0}};
                loss_reg[i]     <= 1'b0;
            end else if (ref_edge[i]) begin
                idle_cnt_reg[i] <= {LOSS_CNT_W{1'b0}};
                loss_reg[i]     <= 1'b0;
            end else if (idle_cnt_reg[i] >= LOSS_LIMIT) begin
                loss_reg[i]     <= 1'b1;
            end else begin
                idle_cnt_reg[i] <= idle_cnt_reg[i] + 1'b1;
            end
        end
    end

    assign req_rise = manual_switch_req & ~req_prev_reg;

    // automatic trigger
    // Selected reference lost; an absent target is waited for in the swap state
    // manual request overrides
    assign auto_trig = loss_reg[sel_reg] && !manual_switch_req;

    // no frequency limit
    // Manual request edge capture; an edge while busy is absorbed, never replayed
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            req_prev_reg <= 1'b0;
        end else begin
            req_prev_reg <= manual_switch_req;
        end
    end

    // Sequencer next state
    // gate then swap
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PRS_RUN: begin
                if (req_rise || auto_trig) begin
                    state_next = PRS_GATE;
                end
            end
            PRS_GATE: begin
                if (ref_fall[sel_reg] || loss_reg[sel_reg]) begin
                    state_next = PRS_SWAP;
                end
            end
            PRS_SWAP: begin
                if (ref_fall[~sel_reg] && !loss_reg[~sel_reg]) begin
                    state_next = PRS_RUN;
                end
            end
        endcase
    end

    // Sequencer state, gating and selection
    // both directions
    // no switch back
    // A lost old reference has no falling edge, so its loss flag stands in
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= PRS_RUN;
            gate_reg  <= 1'b0;
            sel_reg   <= SEL_PRIMARY;
        end else begin
            state_reg <= state_next;
            if (state_reg == PRS_GATE && state_next == PRS_SWAP) begin
                gate_reg <= 1'b1;
            end
            if (state_reg == PRS_SWAP && state_next == PRS_RUN) begin
                gate_reg <= 1'b0;
                sel_reg  <= ~sel_reg;
            end
        end
    end

    // Muxed reference feed, forced low while gated so no runt pulse escapes
    // A lost old reference may hang high, so the feed drops as the gate closes
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            feed_reg <= 1'b0;
        end else begin
            feed_reg <= (gate_reg || state_next == PRS_SWAP) ? 1'b0 : ref_now[sel_reg];
        end
    end

    assign feed_rise = ref_now[sel_reg] & ~gate_reg & ~feed_reg;

    // chaining from strap
    // Taken once after reset release; nothing later can alter it
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cfg_taken_reg <= 1'b0;
            chain_reg     <= CHAIN_RESET;
        end else if (!cfg_taken_reg) begin
            cfg_taken_reg <= 1'b1;
            chain_reg     <= chain_cfg;
        end
    end

    // corrections stop
    // With the phase detector off the oscillator keeps its last frequency
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pfd_reg <= 1'b0;
        end else begin
            pfd_reg <= pfd_enable & ~loop_reset;
        end
    end

    // chained clocking
    // Second divider counts first divider rising edges when chained
    assign div_tick[0] = feed_rise;
    assign div_tick[1] = chain_reg ? (div_out_reg[0] & ~div_prev_reg[0]) : feed_rise;

    // step of one tick
    // Output spends high_cnt ticks high then low_cnt ticks low; the period is
    // their sum, so one count moves the duty cycle by 100% over the divide value
    for (genvar d = 0; d < DIV_NUM; d++) begin : g_div
        always_ff @(posedge clk or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
                div_cnt_reg[d]  <= DIV_CNT_RESET;
                div_out_reg[d]  <= 1'b0;
                div_prev_reg[d] <= 1'b0;
            end else if (loop_reset) begin
                div_cnt_reg[d]  <= DIV_CNT_RESET;
                div_out_reg[d]  <= 1'b0;
                div_prev_reg[d] <= 1'b0;
            end else begin
                div_prev_reg[d] <= div_out_reg[d];
                if (div_tick[d]) begin
                    if (div_cnt_reg[d] <= DIV_CNT_ONE) begin
                        div_out_reg[d] <= ~div_out_reg[d];
                        div_cnt_reg[d] <= div_out_reg[d] ? eff_cnt(div_cfg[d].low_cnt)
                                                         : eff_cnt(div_cfg[d].high_cnt);
                    end else begin
                        div_cnt_reg[d] <= div_cnt_reg[d] - DIV_CNT_ONE;
                    end
                end
            end
        end
    end

    assign status.primary_ref_loss_flag = loss_reg[0];
    assign status.backup_ref_loss_flag  = loss_reg[1];
    assign status.active_sel            = sel_reg;
    assign ref_feed                     = feed_reg;
    assign pfd_correct_en               = pfd_reg;
    assign chain_active                 = chain_reg;
    assign post_divider_first           = div_out_reg[0];
    assign post_divider_second          = div_out_reg[1];

    // Switch sequence steps shared by the checks below
    sequence s_gate_step;
        state_reg == PRS_GATE && (ref_fall[sel_reg] || loss_reg[sel_reg]);
    endsequence

    sequence s_swap_step;
        state_reg == PRS_SWAP && ref_fall[~sel_reg] && !loss_reg[~sel_reg];
    endsequence

    a_loss_after_idle: assert property (
        @(posedge clk) disable iff (!rst_n_reg)
        (!ref_edge[0]) [*1] ##0 (idle_cnt_reg[0] == LOSS_LIMIT) |=> loss_reg[0])
        else $error("primary loss flag not raised after idle time");

    a_loss_clear: assert property (
        @(posedge clk) disable iff (!rst_n_reg)
        ref_edge[1] |=> !loss_reg[1])
        else $error("backup loss flag not cleared by toggle");

    a_gate_old_fall: assert property (
        @(posedge clk) disable iff (!rst_n_reg)
        s_gate_step |=> gate_reg && !feed_reg ##1 !feed_reg)
        else $error("feed not gated after old reference fall");

    a_swap_new_fall: assert property (
        @(posedge clk) disable iff (!rst_n_reg)
        s_swap_step |=> (sel_reg != $past(sel_reg)) && !gate_reg)
        else $error("selection not swapped on new reference fall");

    a_no_switch_back: assert property (
        @(posedge clk) disable iff (!rst_n_reg)
        $fell(manual_switch_req) && state_reg == PRS_RUN && !auto_trig
        |=> state_reg == PRS_RUN)
        else $error("falling request started a switch");

    a_manual_start: assert property (
        @(posedge clk) disable iff (!rst_n_reg)
        req_rise && state_reg == PRS_RUN |=> state_reg == PRS_GATE)
        else $error("rising request did not start a switch");

    a_auto_switch: assert property (
        @(posedge clk) disable iff (!rst_n_reg)
        auto_trig && state_reg == PRS_RUN |=> state_reg == PRS_GATE)
        else $error("automatic switch not started on loss");

    a_wait_target: assert property (
        @(posedge clk) disable iff (!rst_n_reg)
        state_reg == PRS_SWAP && loss_reg[~sel_reg] |=> state_reg == PRS_SWAP && $stable(sel_reg))
        else $error("switch completed onto an absent reference");

    a_pfd_hold: assert property (
        @(posedge clk) disable iff (!rst_n_reg)
        !pfd_enable |=> !pfd_correct_en)
        else $error("corrections not stopped with enable low");

    a_chain_fixed: assert property (
        @(posedge clk) disable iff (!rst_n_reg)
        cfg_taken_reg |=> $stable(chain_active))
        else $error("chaining changed after start");

    a_div_high_time: assert property (
        @(posedge clk) disable iff (!rst_n_reg || loop_reset)
        div_tick[0] && div_cnt_reg[0] <= DIV_CNT_ONE && !div_out_reg[0]
        |=> div_cnt_reg[0] == eff_cnt($past(div_cfg[0].high_cnt)) && div_out_reg[0])
        else $error("first divider high count not loaded");

    a_chain_clock: assert property (
        @(posedge clk) disable iff (!rst_n_reg || loop_reset)
        chain_reg && div_tick[1] |-> $rose(div_out_reg[0]))
        else $error("chained divider ticked without first divider edge");

endmodule

// File: prs_ref_switch_tb.sv
// Self-checking bench for the reference switchover and post-divider block.
// Assumes prs_ref_model supplies the references; all other inputs change on falling clk edges.
`timescale 1ns/1ps
module prs_ref_switch_tb;
    import prs_pkg::*;

    localparam int LIMIT = 20000;
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    logic         run_p = 1'b1;
    logic         run_b = 1'b1;
    logic         manual_switch_req = 1'b0;
    logic         pfd_enable = 1'b1;
    logic         loop_reset = 1'b0;
    logic         chain_cfg = 1'b1;
    logic         primary_ref_input;
    logic         backup_ref_input;
    prs_div_cfg_s div_cfg [DIV_NUM];
    prs_status_s  status;
    logic         ref_feed;
    logic         pfd_correct_en;
    logic         chain_active;
    logic         post_divider_first;
    logic         post_divider_second;
    int           n_errors = 0;
    int           total_checks = 0;
    int           cycles = 0;
    logic [15:0]  hi;
    logic [15:0]  lo;

    // 25 MHz clock
    always #20 clk = ~clk;

    prs_ref_model #(.HALF(2)) ref_u (
        .clk               (clk),
        .run_primary       (run_p),
        .run_backup        (run_b),
        .primary_ref_input (primary_ref_input),
        .backup_ref_input  (backup_ref_input)
    );

    prs_ref_switch #(.REF_PERIOD(4)) dut_u (
        .clk                 (clk),
        .nrst                (nrst),
        .primary_ref_input   (primary_ref_input),
        .backup_ref_input    (backup_ref_input),
        .manual_switch_req   (manual_switch_req),
        .pfd_enable          (pfd_enable),
        .loop_reset          (loop_reset),
        .chain_cfg           (chain_cfg),
        .div_cfg             (div_cfg),
        .status              (status),
        .ref_feed            (ref_feed),
        .pfd_correct_en      (pfd_correct_en),
        .chain_active        (chain_active),
        .post_divider_first  (post_divider_first),
        .post_divider_second (post_divider_second)
    );

    // Single comparison point, so every check is counted the same way
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Bounded wait on one status bit: 2 loss flag primary, 1 loss flag backup, 0 selection
    task automatic wait_st(input int idx, input logic v, input string nm);
        int n;
        n = 0;
        while (status[idx] !== v && n < 200) begin
            @(negedge clk);
            n++;
        end
        check(nm, {15'h0000, status[idx]}, {15'h0000, v});
    endtask

    // Measures high and low time in clk cycles of one divider output
    function automatic logic div_out(input int which);
        return (which == 0) ? post_divider_first : post_divider_second;
    endfunction

    task automatic measure(input int which, output logic [15:0] h, output logic [15:0] l);
        int n;
        n = 0;
        h = 16'h0000;
        l = 16'h0000;
        while (div_out(which) !== 1'b0 && n < 400) begin @(negedge clk); n++; end
        while (div_out(which) !== 1'b1 && n < 400) begin @(negedge clk); n++; end
        while (div_out(which) === 1'b1 && n < 400) begin @(negedge clk); n++; h++; end
        while (div_out(which) === 1'b0 && n < 400) begin @(negedge clk); n++; l++; end
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        div_cfg[0] = '{high_cnt: 10'h002, low_cnt: 10'h002};
        div_cfg[1] = '{high_cnt: 10'h001, low_cnt: 10'h001};
        repeat (5) @(negedge clk);
        check("status in reset", {13'h0000, status}, 16'h0000);
        nrst = 1'b1;
        repeat (6) @(negedge clk);
        check("chain active", {15'h0000, chain_active}, 16'h0001);
        chain_cfg = 1'b0;
        $display("test reset done");

        // Reference period is 4 clk: 2+2 ticks give 8 high, 8 low
        measure(0, hi, lo);
        check("first high time", hi, 16'h0008);
        check("first low time", lo, 16'h0008);
        // Chained 1+1 behind a 16 clk period gives 16 high, 16 low
        measure(1, hi, lo);
        check("chained high", hi, 16'h0010);
        check("chained low", lo, 16'h0010);
        check("chain after strap change", {15'h0000, chain_active}, 16'h0001);
        // Divide value 4 gives 25% steps; one step below 50% is 4 of 16 clk high
        div_cfg[0] = '{high_cnt: 10'h001, low_cnt: 10'h003};
        measure(0, hi, lo);
        measure(0, hi, lo);
        check("quarter duty high", hi, 16'h0004);
        check("quarter duty low", lo, 16'h000C);
        loop_reset = 1'b1;
        repeat (3) @(negedge clk);
        check("divider cleared", {15'h0000, post_divider_first}, 16'h0000);
        check("corrections in loop reset", {15'h0000, pfd_correct_en}, 16'h0000);
        loop_reset = 1'b0;
        $display("test dividers done");

        pfd_enable = 1'b0;
        @(negedge clk);
        check("corrections off", {15'h0000, pfd_correct_en}, 16'h0000);
        pfd_enable = 1'b1;
        @(negedge clk);
        check("corrections on", {15'h0000, pfd_correct_en}, 16'h0001);
        $display("test phase detector done");

        // Automatic loss and return in both directions
        run_p = 1'b0;
        wait_st(2, 1'b1, "primary loss");
        wait_st(0, 1'b1, "auto to backup");
        check("backup flag clear", {15'h0000, status[1]}, 16'h0000);
        // loop reset pulsed after the switch
        loop_reset = 1'b1;
        @(negedge clk);
        loop_reset = 1'b0;
        // divider output read only once the new feed has settled
        measure(0, hi, lo);
        measure(0, hi, lo);
        check("backup feed high", hi, 16'h0004);
        check("backup feed low", lo, 16'h000C);
        run_p = 1'b1;
        wait_st(2, 1'b0, "primary loss clears");
        run_b = 1'b0;
        wait_st(1, 1'b1, "backup loss");
        wait_st(0, 1'b0, "auto back to primary");
        run_b = 1'b1;
        wait_st(1, 1'b0, "backup loss clears");
        repeat (20) @(negedge clk);
        $display("test automatic done");

        // Manual override, both references running
        // both references toggling
        manual_switch_req = 1'b1;
        wait_st(0, 1'b1, "manual to backup");
        // request held over four reference periods
        repeat (16) @(negedge clk);
        check("no loss in manual", {14'h0000, status[2:1]}, 16'h0000);
        manual_switch_req = 1'b0;
        repeat (30) @(negedge clk);
        check("fall keeps backup", {15'h0000, status.active_sel}, 16'h0001);
        manual_switch_req = 1'b1;
        wait_st(0, 1'b0, "second rise to primary");
        repeat (16) @(negedge clk);
        // Selected reference dies while request is high: no action
        run_p = 1'b0;
        wait_st(2, 1'b1, "primary loss during hold");
        repeat (40) @(negedge clk);
        check("held request blocks", {15'h0000, status.active_sel}, 16'h0000);
        check("ref feed idle", {15'h0000, ref_feed}, {15'h0000, primary_ref_input});
        manual_switch_req = 1'b0;
        wait_st(0, 1'b1, "auto after release");
        $display("test manual done");

        // Both lost: selection waits until a target toggles again
        run_b = 1'b0;
        wait_st(1, 1'b1, "backup loss both");
        repeat (40) @(negedge clk);
        check("waits for target", {15'h0000, status.active_sel}, 16'h0001);
        run_p = 1'b1;
        wait_st(0, 1'b0, "completes when back");
        run_b = 1'b1;
        wait_st(1, 1'b0, "backup clears end");
        $display("test wait for target done");
        end_sim();
    end
endmodule
